//--- hw/led_bank_defs.svh
// offsets, field positions and reset values of the led bank register set
// assumes a 32-bit apb slave with each register on one aligned word
`ifndef LED_BANK_DEFS_SVH
`define LED_BANK_DEFS_SVH

// register indexes; byte address is four times the index
`define IDX_FS_A       6'h17
`define IDX_CFG_B      6'h18
`define IDX_FS_B       6'h19
`define IDX_CFG_C      6'h1a
`define IDX_FS_C       6'h1b
`define IDX_FEEDBACK   6'h1c
`define IDX_ENABLE     6'h1d

// field positions
`define CFG_SRC_BIT    0
`define CFG_LIN_BIT    1
`define CFG_PTR_LSB    2
`define CFG_PTR_MSB    4
`define FS_MSB         4

// reset values, plus the target code of the top zone
`define CFG_RESET      5'h11
`define FS_RESET       5'h13
`define FEEDBACK_RESET 3'h7
`define ENABLE_RESET   3'h0
`define ZONE_TOP       3'h4

`endif

//--- hw/led_bank_pkg.sv
// types shared by the led bank register block
// assumes the constants header is included by the user
package led_bank_pkg;

    // which bank a current sink is assigned to
    typedef enum logic [1:0] {
        SINK_BANK_A    = 2'b00,
        SINK_BANK_B    = 2'b01,
        SINK_BANK_C    = 2'b10,
        SINK_BANK_NONE = 2'b11
    } sink_bank_t;

    // steering handed to one current control bank
    typedef struct packed {
        logic       enable;      // bank switched on
        logic       bus_mode;    // 1 = bus target, 0 = ambient zone
        logic       linear;      // 1 = linear, 0 = exponential mapping
        logic [2:0] target;      // zone target index 0..4
        logic [4:0] full_scale;  // full-scale current code
    } bank_ctrl_t;

endpackage

//--- hw/led_bank_regs.sv
// apb register bank steering three led current control banks and their sinks
// assumes sink-to-bank assignment and the ambient zone arrive from other blocks
`include "led_bank_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module led_bank_regs (
    input  wire logic                   ref_clk_in,      // 125 mhz clock
    input  wire logic                   rst_n_in,        // sync reset, low
    input  wire logic                   psel_in,         // apb select
    input  wire logic                   penable_in,      // apb access phase
    input  wire logic                   pwrite_in,       // apb write
    input  wire logic [7:0]             paddr_in,        // apb byte address
    input  wire logic [31:0]            pwdata_in,       // apb write data
    output logic      [31:0]            prdata_out,      // apb read data
    output logic                        pready_out,      // apb ready
    output logic                        pslverr_out,     // apb error
    input  wire logic [2:0]             als_zone_in,     // averaged zone
    input  wire led_bank_pkg::sink_bank_t sink_bank_in [3], // sink assignment
    output led_bank_pkg::bank_ctrl_t    bank_ctrl_out [3],  // per-bank steering
    output logic      [2:0]             sink_on_out,     // sinks 1..3 on
    output logic      [2:0]             sink_feedback_out // sinks in boost loop
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [4:0]  cfg_b_reg;
    logic [4:0]  cfg_b_next;
    logic [4:0]  cfg_c_reg;
    logic [4:0]  cfg_c_next;
    logic [4:0]  fs_reg [3];
    logic [4:0]  fs_next [3];
    logic [2:0]  feedback_reg;
    logic [2:0]  feedback_next;
    logic [2:0]  enable_reg;
    logic [2:0]  enable_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    led_bank_pkg::bank_ctrl_t bank_reg [3];
    led_bank_pkg::bank_ctrl_t bank_next [3];
    logic [2:0]  sink_on_reg;
    logic [2:0]  sink_on_next;
    logic [2:0]  sink_fb_reg;
    logic [2:0]  sink_fb_next;

    logic        access;
    logic        wr_en;
    logic        hit;
    logic [5:0]  idx;
    logic [31:0] rd_word;

    // 1xx pointer codes all mean the top zone
    function automatic logic [2:0] zone_norm(input logic [2:0] code);
        zone_norm = code[2] ? `ZONE_TOP : code;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb decode; one wait state so read data comes from a flop
    assign idx    = paddr_in[7:2];
    assign access = psel_in && penable_in;
    assign wr_en  = access && pready_reg && pwrite_in && hit;

    // address hit and read mux; upper bits are zero by construction
    always_comb begin
        hit     = (paddr_in[1:0] == 2'h0);
        rd_word = 32'h0;
        unique case (idx)
            `IDX_FS_A:     rd_word = {27'h0, fs_reg[0]};
            `IDX_CFG_B:    rd_word = {27'h0, cfg_b_reg};
            `IDX_FS_B:     rd_word = {27'h0, fs_reg[1]};
            `IDX_CFG_C:    rd_word = {27'h0, cfg_c_reg};
            `IDX_FS_C:     rd_word = {27'h0, fs_reg[2]};
            `IDX_FEEDBACK: rd_word = {29'h0, feedback_reg};
            `IDX_ENABLE:   rd_word = {29'h0, enable_reg};
            default:       hit     = 1'b0;
        endcase
    end

    // bus response; ready rises on the second access cycle
    always_comb begin
        pready_next  = 1'b0;
        pslverr_next = pslverr_reg;
        prdata_next  = prdata_reg;
        if (access && !pready_reg) begin
            pready_next  = 1'b1;
            pslverr_next = !hit;
            prdata_next  = (hit && !pwrite_in) ? rd_word : 32'h0;
        end
    end

    // register writes; only the low bits are kept, so the rest ignore writes
    always_comb begin
        cfg_b_next    = cfg_b_reg;
        cfg_c_next    = cfg_c_reg;
        fs_next       = fs_reg;
        feedback_next = feedback_reg;
        enable_next   = enable_reg;
        if (wr_en) begin
            unique case (idx)
                `IDX_FS_A:     fs_next[0]    = pwdata_in[`FS_MSB:0];
                `IDX_CFG_B:    cfg_b_next    = pwdata_in[4:0];
                `IDX_FS_B:     fs_next[1]    = pwdata_in[`FS_MSB:0];
                `IDX_CFG_C:    cfg_c_next    = pwdata_in[4:0];
                `IDX_FS_C:     fs_next[2]    = pwdata_in[`FS_MSB:0];
                `IDX_FEEDBACK: feedback_next = pwdata_in[2:0];
                `IDX_ENABLE:   enable_next   = pwdata_in[2:0];
                default:       enable_next   = enable_reg;
            endcase
        end
    end

    // register file flops
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            cfg_b_reg    <= `CFG_RESET;
            cfg_c_reg    <= `CFG_RESET;
            fs_reg[0]    <= `FS_RESET;
            fs_reg[1]    <= `FS_RESET;
            fs_reg[2]    <= `FS_RESET;
            feedback_reg <= `FEEDBACK_RESET;
            enable_reg   <= `ENABLE_RESET;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
            prdata_reg   <= 32'h0;
        end else begin
            cfg_b_reg    <= cfg_b_next;
            cfg_c_reg    <= cfg_c_next;
            fs_reg       <= fs_next;
            feedback_reg <= feedback_next;
            enable_reg   <= enable_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
            prdata_reg   <= prdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sink steering; registered once more so outputs come from flops
    always_comb begin
        // bank a brightness config lives elsewhere: fixed ambient, exponential
        bank_next[0] = '{enable: enable_reg[0], bus_mode: 1'b0, linear: 1'b0,
                         target: zone_norm(als_zone_in), full_scale: fs_reg[0]};
        bank_next[1] = '{enable:     enable_reg[1],
                         bus_mode:   cfg_b_reg[`CFG_SRC_BIT],
                         linear:     cfg_b_reg[`CFG_LIN_BIT],
                         target:     cfg_b_reg[`CFG_SRC_BIT]
                                     ? zone_norm(cfg_b_reg[`CFG_PTR_MSB:`CFG_PTR_LSB])
                                     : zone_norm(als_zone_in),
                         full_scale: fs_reg[1]};
        bank_next[2] = '{enable:     enable_reg[2],
                         bus_mode:   cfg_c_reg[`CFG_SRC_BIT],
                         linear:     cfg_c_reg[`CFG_LIN_BIT],
                         target:     cfg_c_reg[`CFG_SRC_BIT]
                                     ? zone_norm(cfg_c_reg[`CFG_PTR_MSB:`CFG_PTR_LSB])
                                     : zone_norm(als_zone_in),
                         full_scale: fs_reg[2]};
        for (int s = 0; s < 3; s++) begin
            // unassigned sinks stay off whatever the enables say
            unique case (sink_bank_in[s])
                led_bank_pkg::SINK_BANK_A: sink_on_next[s] = enable_reg[0];
                led_bank_pkg::SINK_BANK_B: sink_on_next[s] = enable_reg[1];
                led_bank_pkg::SINK_BANK_C: sink_on_next[s] = enable_reg[2];
                default:                   sink_on_next[s] = 1'b0;
            endcase
        end
        sink_fb_next = feedback_reg;
    end

    // output flops; a write shows here one clock after it completes
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int b = 0; b < 3; b++) begin
                bank_reg[b] <= '{enable: 1'b0, bus_mode: 1'b0, linear: 1'b0,
                                 target: 3'h0, full_scale: `FS_RESET};
            end
            sink_on_reg <= 3'h0;
            sink_fb_reg <= `FEEDBACK_RESET;
        end else begin
            bank_reg    <= bank_next;
            sink_on_reg <= sink_on_next;
            sink_fb_reg <= sink_fb_next;
        end
    end

    assign prdata_out        = prdata_reg;
    assign pready_out        = pready_reg;
    assign pslverr_out       = pslverr_reg;
    assign bank_ctrl_out     = bank_reg;
    assign sink_on_out       = sink_on_reg;
    assign sink_feedback_out = sink_fb_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence enable_write_s;
        wr_en && (idx == `IDX_ENABLE);
    endsequence

    sequence two_clocks_s;
        1'b1 ##2 1'b1;
    endsequence

    enable_reach_a: assert property (enable_write_s |-> ##2
        {bank_ctrl_out[2].enable, bank_ctrl_out[1].enable,
         bank_ctrl_out[0].enable} == $past(pwdata_in[2:0], 2))
        else $error("bank enable did not follow write");

    sink_follow_a: assert property (
        (sink_bank_in[0] == led_bank_pkg::SINK_BANK_A) && enable_reg[0]
        && $stable(sink_bank_in[0]) |=> sink_on_out[0])
        else $error("sink 1 not on with its bank enabled");

    src_b_mode_a: assert property (
        $past(rst_n_in) |-> bank_ctrl_out[1].bus_mode == $past(cfg_b_reg[0]))
        else $error("bank b source select wrong");

    ptr_c_top_a: assert property (
        cfg_c_reg[0] && cfg_c_reg[4] |=> bank_ctrl_out[2].target == 3'h4)
        else $error("bank c pointer 1xx not target 4");

    ptr_b_low_a: assert property (
        cfg_b_reg[0] && !cfg_b_reg[4] |=> bank_ctrl_out[1].target == $past(cfg_b_reg[4:2]))
        else $error("bank b pointer target wrong");

    als_zone_a: assert property (
        !cfg_b_reg[0] && !als_zone_in[2] |=> bank_ctrl_out[1].target == $past(als_zone_in))
        else $error("ambient zone not passed to bank b");

    upper_zero_a: assert property (
        pready_out && !pwrite_in |-> prdata_out[31:5] == 27'h0)
        else $error("unused read bits not zero");

    fs_write_a: assert property (
        wr_en && (idx == `IDX_FS_C) |=> fs_reg[2] == $past(pwdata_in[4:0]))
        else $error("bank c full scale write lost");

    fb_reach_a: assert property (
        wr_en && (idx == `IDX_FEEDBACK) |-> two_clocks_s
        ##0 sink_feedback_out == $past(pwdata_in[2:0], 2))
        else $error("feedback select did not follow write");

    lin_c_a: assert property (
        $past(rst_n_in) |-> bank_ctrl_out[2].linear == $past(cfg_c_reg[1]))
        else $error("bank c mapping select wrong");

    ready_pulse_a: assert property (
        pready_out |=> !pready_out)
        else $error("ready held more than one cycle");

    sequence first_access_s;
        access && !pready_reg;
    endsequence

    sequence refused_s;
        first_access_s ##0 !hit;
    endsequence

    // exactly one wait state before the answer
    ready_wait_a: assert property (
        first_access_s |=> pready_out)
        else $error("ready not in second access cycle");

    // bad addresses answer with an error
    err_refuse_a: assert property (
        refused_s |=> pready_out && pslverr_out)
        else $error("refused access gave no error");

    // refused accesses leave enable and feedback unchanged into the ready cycle
    no_wr_refused_a: assert property (
        refused_s |=> $stable(enable_reg) && $stable(feedback_reg))
        else $error("refused write changed a register");

    // writes answer with zero data
    read_zero_wr_a: assert property (
        pready_out && pwrite_in |-> prdata_out == 32'h0)
        else $error("write answer carried data");

    // enable register takes the low bits
    enable_store_a: assert property (
        enable_write_s |=> enable_reg == $past(pwdata_in[2:0]))
        else $error("enable write lost");

    // bank c source reaches its output
    src_c_mode_a: assert property (
        $past(rst_n_in) |-> bank_ctrl_out[2].bus_mode == $past(cfg_c_reg[0]))
        else $error("bank c source select wrong");

    // bank b mapping reaches its output
    lin_b_a: assert property (
        $past(rst_n_in) |-> bank_ctrl_out[1].linear == $past(cfg_b_reg[1]))
        else $error("bank b mapping select wrong");

    // bank b 1xx pointer folds to the top target
    ptr_b_top_a: assert property (
        cfg_b_reg[0] && cfg_b_reg[4] |=> bank_ctrl_out[1].target == 3'h4)
        else $error("bank b pointer 1xx not target 4");

    // bank c low pointer codes pass through
    ptr_c_low_a: assert property (
        cfg_c_reg[0] && !cfg_c_reg[4] |=> bank_ctrl_out[2].target == $past(cfg_c_reg[4:2]))
        else $error("bank c pointer target wrong");

    // ambient zone reaches bank c in ambient mode
    als_zone_c_a: assert property (
        !cfg_c_reg[0] && !als_zone_in[2] |=> bank_ctrl_out[2].target == $past(als_zone_in))
        else $error("ambient zone not passed to bank c");

    // top ambient zones fold to target 4
    als_top_a: assert property (
        !cfg_b_reg[0] && als_zone_in[2] |=> bank_ctrl_out[1].target == 3'h4)
        else $error("ambient zone 1xx not target 4");

    // bank a full-scale write lands
    fs_a_write_a: assert property (
        wr_en && (idx == `IDX_FS_A) |=> fs_reg[0] == $past(pwdata_in[4:0]))
        else $error("bank a full scale write lost");

    // bank b full-scale write lands
    fs_b_write_a: assert property (
        wr_en && (idx == `IDX_FS_B) |=> fs_reg[1] == $past(pwdata_in[4:0]))
        else $error("bank b full scale write lost");

    // bank b full-scale code reaches its output
    fs_reach_a: assert property (
        $past(rst_n_in) |-> bank_ctrl_out[1].full_scale == $past(fs_reg[1]))
        else $error("bank b full scale not at output");

    // an unassigned sink stays off
    sink_off_a: assert property (
        sink_bank_in[1] == led_bank_pkg::SINK_BANK_NONE |=> !sink_on_out[1])
        else $error("unassigned sink 2 on");

    // sink on bank c follows its enable
    sink_c_follow_a: assert property (
        (sink_bank_in[2] == led_bank_pkg::SINK_BANK_C) && enable_reg[2]
        |=> sink_on_out[2])
        else $error("sink 3 not on with its bank enabled");

endmodule

`default_nettype wire

//--- verif/led_bank_regs_tb.sv
// self-checking bench for the led bank apb register block
// assumes the design files and the constants header are on the include path
`include "led_bank_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module led_bank_regs_tb;

////////////////////////////////////////////////////////////////////////////////
    logic                     ref_clk_in = 1'b0;
    logic                     rst_n_in = 1'b0;
    logic                     psel_in = 1'b0;
    logic                     penable_in = 1'b0;
    logic                     pwrite_in = 1'b0;
    logic [7:0]               paddr_in = 8'h00;
    logic [31:0]              pwdata_in = 32'h0;
    logic [31:0]              prdata_out;
    logic                     pready_out;
    logic                     pslverr_out;
    logic [2:0]               als_zone_in = 3'h6;
    led_bank_pkg::sink_bank_t sink_bank_in [3];
    led_bank_pkg::bank_ctrl_t bank_ctrl_out [3];
    logic [2:0]               sink_on_out;
    logic [2:0]               sink_feedback_out;
    int                       fail_count = 0;
    int                       compares = 0;
    logic [31:0]              rd;
    logic                     err;
    int                       q;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
    } row_t;

    // upper bits set in every write but the bank b full-scale row so dropped bits show up on readback
    row_t rows [7] = '{
        '{{`IDX_FS_A, 2'b00},     32'hffffffea, 32'h0000000a},
        '{{`IDX_CFG_B, 2'b00},    32'hffffff0e, 32'h0000000e},
        '{{`IDX_FS_B, 2'b00},     32'h0000001f, 32'h0000001f},
        '{{`IDX_CFG_C, 2'b00},    32'hfffffff3, 32'h00000013},
        '{{`IDX_FS_C, 2'b00},     32'hffffffe0, 32'h00000000},
        '{{`IDX_FEEDBACK, 2'b00}, 32'hfffffffa, 32'h00000002},
        '{{`IDX_ENABLE, 2'b00},   32'hfffffff5, 32'h00000005}
    };

    // clock at 125 mhz
    always #4 ref_clk_in = ~ref_clk_in;

    led_bank_regs i_dut (
        .ref_clk_in        (ref_clk_in),
        .rst_n_in          (rst_n_in),
        .psel_in           (psel_in),
        .penable_in        (penable_in),
        .pwrite_in         (pwrite_in),
        .paddr_in          (paddr_in),
        .pwdata_in         (pwdata_in),
        .prdata_out        (prdata_out),
        .pready_out        (pready_out),
        .pslverr_out       (pslverr_out),
        .als_zone_in       (als_zone_in),
        .sink_bank_in      (sink_bank_in),
        .bank_ctrl_out     (bank_ctrl_out),
        .sink_on_out       (sink_on_out),
        .sink_feedback_out (sink_feedback_out)
    );

////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] ctl(input logic en, input logic bm, input logic lin,
                                        input logic [2:0] tg, input logic [4:0] fs);
        return {21'h0, en, bm, lin, tg, fs};
    endfunction

    // one apb transfer; an idle edge first keeps strobes from double assignment
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        // a slave that never answers counts as a mismatch
        if (pready_out !== 1'b1) begin
            fail_count++;
        end
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // bank ctrl of one bank, widened for the compare task
    function automatic logic [31:0] bk(input int i);
        return {21'h0, bank_ctrl_out[i]};
    endfunction

////////////////////////////////////////////////////////////////////////////////
    // watchdog; whole run is under two hundred cycles
    initial begin
        #200000;
        fail_count++;
        final_report();
    end

    initial begin
        sink_bank_in = '{led_bank_pkg::SINK_BANK_A, led_bank_pkg::SINK_BANK_B,
                         led_bank_pkg::SINK_BANK_C};
        repeat (16) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1;
        // reset state at the outputs
        check(bk(1), ctl(1'b0, 1'b1, 1'b0, 3'h4, 5'h13));
        check(bk(2), ctl(1'b0, 1'b1, 1'b0, 3'h4, 5'h13));
        check({29'h0, sink_feedback_out}, 32'h7);
        check({29'h0, sink_on_out}, 32'h0);
        // reset readback of every register
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, rows[i].addr, 32'h0, rd, err);
            check(rd, (i == 1 || i == 3) ? 32'h11 : (i == 5) ? 32'h7 :
                      (i == 6) ? 32'h0 : 32'h13);
        end
        // table: write, read back, no error
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata, rd, err);
            check({31'h0, err}, 32'h0);
            apb(1'b0, rows[i].addr, 32'h0, rd, err);
            check(rd, rows[i].rexp);
        end
        @(posedge ref_clk_in);
        #1;
        check(bk(0), ctl(1'b1, 1'b0, 1'b0, 3'h4, 5'h0a));
        check(bk(1), ctl(1'b0, 1'b0, 1'b1, 3'h4, 5'h1f));
        check(bk(2), ctl(1'b1, 1'b1, 1'b1, 3'h4, 5'h00));
        check({29'h0, sink_feedback_out}, 32'h2);
        check({29'h0, sink_on_out}, 32'h5);
        // ambient zone reaches the banks in ambient mode only
        @(posedge ref_clk_in);
        als_zone_in <= 3'h2;
        repeat (2) @(posedge ref_clk_in);
        #1;
        check(bk(1), ctl(1'b0, 1'b0, 1'b1, 3'h2, 5'h1f));
        check(bk(2), ctl(1'b1, 1'b1, 1'b1, 3'h4, 5'h00));
        // sink reassigned to an enabled bank, then to none
        @(posedge ref_clk_in);
        sink_bank_in[1] <= led_bank_pkg::SINK_BANK_C;
        repeat (2) @(posedge ref_clk_in);
        #1;
        check({29'h0, sink_on_out}, 32'h7);
        @(posedge ref_clk_in);
        sink_bank_in[1] <= led_bank_pkg::SINK_BANK_NONE;
        repeat (2) @(posedge ref_clk_in);
        #1;
        check({29'h0, sink_on_out}, 32'h5);
        // bus mode with every pointer code, 1xx folding to target 4
        for (int p = 0; p < 8; p++) begin
            apb(1'b1, {`IDX_CFG_B, 2'b00}, {27'h0, p[2:0], 2'b01}, rd, err);
            #1;
            // before the next clock the previous pointer still shows
            q = p - 1;
            check(bk(1), (p == 0) ? ctl(1'b0, 1'b0, 1'b1, 3'h2, 5'h1f)
                                  : ctl(1'b0, 1'b1, 1'b0, q[2] ? 3'h4 : q[2:0], 5'h1f));
            @(posedge ref_clk_in);
            #1;
            check(bk(1), ctl(1'b0, 1'b1, 1'b0, p[2] ? 3'h4 : p[2:0], 5'h1f));
        end
        // enable write lands one clock after completion
        apb(1'b1, {`IDX_ENABLE, 2'b00}, 32'h2, rd, err);
        #1;
        check({29'h0, sink_on_out}, 32'h5);
        @(posedge ref_clk_in);
        #1;
        check({29'h0, sink_on_out}, 32'h0);
        check(bk(1), ctl(1'b1, 1'b1, 1'b0, 3'h4, 5'h1f));
        // unmapped and misaligned accesses are refused and change nothing
        apb(1'b1, 8'h78, 32'h1f, rd, err);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 8'h78, 32'h0, rd, err);
        check({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 8'h75, 32'h7, rd, err);
        check({31'h0, err}, 32'h1);
        apb(1'b0, {`IDX_ENABLE, 2'b00}, 32'h0, rd, err);
        check(rd, 32'h2);
        final_report();
    end

endmodule

`default_nettype wire
